//--- rtl/oss_pkg.sv
/*
 * Constants and carrier types for the operational status reporter.
 * Assumes a single core clock; the register is reached through the
 * device's internal serial-command register port, one byte per address.
 */
// Operation
// - host may read the eight-bit status register anytime, in any state.
// - bit 7 mirrors the ready output pin; high when commands accepted.
// - bit 6 high once run asserted and normal operating mode entered.
// - bit 5 set on safe-mode entry after self-test or boot-load failure.
// - bit 4 high throughout RAM integrity check and RAM clearing.
// - bit 3 high while an external EEPROM programming cycle runs.
// - ready held low during EEPROM programming, raised after it ends.
// - bit 2 high while loading memory and tables from boot EEPROM.
// - bit 0 set when an external CAN controller has been detected.
// - after CAN controller init, bit 0 frozen in modes 6 and 7.
// - run low with ready high is idle; only then config writes allowed.
package oss_pkg;

    // register map
    localparam logic [15:0] OSS_STATUS_ADDR  = 16'h800e;
    localparam logic [7:0]  OSS_STATUS_RESET = 8'h00;

    // field positions inside the status byte
    localparam int OSS_BIT_READY   = 7;
    localparam int OSS_BIT_ACTIVE  = 6;
    localparam int OSS_BIT_SAFE    = 5;
    localparam int OSS_BIT_RAMCHK  = 4;
    localparam int OSS_BIT_EEPROG  = 3;
    localparam int OSS_BIT_BOOT    = 2;
    localparam int OSS_BIT_UNUSED  = 1;
    localparam int OSS_BIT_CANDET  = 0;

    // operating modes in which the presence bit is frozen
    localparam logic [2:0] OSS_MODE_FREEZE_A = 3'h6;
    localparam logic [2:0] OSS_MODE_FREEZE_B = 3'h7;

    // synchroniser depth for pin inputs
    localparam int OSS_SYNC_STAGES = 3;

    // internal condition sources from the rest of the device
    typedef struct packed {
        logic       core_ready;      // command engine able to serve host
        logic       normal_mode;     // device in normal operating mode
        logic       selftest_fail;   // one-cycle pulse
        logic       bootload_fail;   // one-cycle pulse
        logic       ram_check_in_progress;
        logic       eeprom_write_in_progress;
        logic       boot_load_in_progress;
        logic       can_detect;      // presence seen on CAN serial port
        logic       can_init_done;   // external CAN controller initialised
        logic [2:0] op_mode;
    } oss_src_t;

    // register access request from the serial command decoder
    typedef struct packed {
        logic        valid;          // one-cycle pulse
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } oss_req_t;

    // read answer to the serial command decoder
    typedef struct packed {
        logic       valid;           // one-cycle pulse
        logic [7:0] data;
    } oss_rsp_t;

endpackage

//--- rtl/oss_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the input is asynchronous to core_clk; the output changes only
 * once the second and third stages agree, so one glitch cannot pass.
 */
module oss_pin_sync
    import oss_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // asynchronous pins
    input  wire logic [WIDTH-1:0] pin_in,
    // filtered, synchronous levels
    output logic      [WIDTH-1:0] level_out
);

    initial begin
        if (WIDTH < 1) $error("oss_pin_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [WIDTH-1:0] lvl_next;

    // accept a new level only when stages two and three agree
    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) lvl_next[i] = s3_reg[i];
        end
    end

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;

endmodule // oss_pin_sync

//--- rtl/oss_status_reporter.sv
/*
 * Operational status reporter: the read-only status byte, the ready
 * output pin and the idle qualifier for configuration writes, plus a
 * qualifier that tells the rest of the device when the presence bit
 * of the external CAN controller means anything.
 * Assumes the serial command decoder presents one access at a time as a
 * one-cycle request and takes the answer one cycle later; other
 * addresses belong to other register blocks and get no answer here.
 * Assumes the condition sources come from core_clk logic and need no
 * synchroniser; only the run pin is asynchronous and is filtered.
 * Assumes a synchronous, active-low reset long enough to flush the
 * run synchroniser; every output reads zero while it is held.
 * Status conditions show on the byte one cycle after their source,
 * and the run pin a few cycles later because of its filter.
 */
module oss_status_reporter
    import oss_pkg::*;
#(
    parameter int STATUS_WIDTH = 8
) (
    // clock and reset
    input  wire logic     core_clk,
    input  wire logic     rst_n,
    // device pins, asynchronous
    input  wire logic     run_pin,
    // internal condition sources, core_clk domain
    input  wire oss_src_t src,
    input  wire logic     can_transmit_enable,
    input  wire logic     can_receive_enable,
    // register port from the serial command decoder
    input  wire oss_req_t req,
    output oss_rsp_t      rsp,
    // ready output pin
    output logic          ready_pin,
    // qualifiers for the rest of the device
    output logic          cfg_write_allowed,
    output logic          can_status_valid,
    output logic [7:0]    status_out
);

    // the byte layout is fixed; a different width cannot be served
    initial begin
        if (STATUS_WIDTH != 8) begin
            $error("oss_status_reporter: STATUS_WIDTH must be 8");
        end
    end

    // each field must land inside the byte, or its condition is lost
    initial begin
        if (OSS_BIT_READY  >= STATUS_WIDTH ||
            OSS_BIT_ACTIVE >= STATUS_WIDTH ||
            OSS_BIT_SAFE   >= STATUS_WIDTH ||
            OSS_BIT_RAMCHK >= STATUS_WIDTH ||
            OSS_BIT_EEPROG >= STATUS_WIDTH ||
            OSS_BIT_BOOT   >= STATUS_WIDTH ||
            OSS_BIT_UNUSED >= STATUS_WIDTH ||
            OSS_BIT_CANDET >= STATUS_WIDTH) begin
            $error("oss_status_reporter: status field outside the byte");
        end
    end

    // the run synchroniser is built with exactly three stages
    initial begin
        if (OSS_SYNC_STAGES != 3) begin
            $error("oss_status_reporter: OSS_SYNC_STAGES must be 3");
        end
    end

    // synchronised run level
    logic run_sync;

    oss_pin_sync #(
        .WIDTH     (1)
    ) u_run_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    (run_pin),
        .level_out (run_sync)
    );

    // state
    logic       ready_reg,      ready_next;
    logic       active_reg,     active_next;
    logic       safe_reg,       safe_next;
    logic       ramchk_reg,     ramchk_next;
    logic       eeprog_reg,     eeprog_next;
    logic       boot_reg,       boot_next;
    logic       candet_reg,     candet_next;
    logic       idle_reg,       idle_next;
    logic       canvalid_reg,   canvalid_next;
    logic [7:0] status_reg,     status_next;
    oss_rsp_t   rsp_reg,        rsp_next;

    logic       can_frozen;
    logic       ready_eff;
    logic       freeze_mode;
    logic       read_hit;

    // modes 6 and 7 are the ones in which the presence bit may freeze
    always_comb begin
        freeze_mode = (src.op_mode == OSS_MODE_FREEZE_A) ||
                      (src.op_mode == OSS_MODE_FREEZE_B);
    end

    // presence bit stops tracking once the controller is set up in 6 or 7
    always_comb begin
        can_frozen = src.can_init_done && freeze_mode;
    end

    // ready never rises while an eeprom programming cycle runs
    always_comb begin
        ready_eff = src.core_ready &&
                    !src.eeprom_write_in_progress;
    end

    // next values of the status conditions
    always_comb begin
        ready_next    = ready_eff;
        active_next   = run_sync && src.normal_mode;
        // safe mode only ends with a device reset, so the bit is sticky
        safe_next     = safe_reg || src.selftest_fail ||
                        src.bootload_fail;
        ramchk_next   = src.ram_check_in_progress;
        eeprog_next   = src.eeprom_write_in_progress;
        boot_next     = src.boot_load_in_progress;
        candet_next   = can_frozen ? candet_reg : src.can_detect;
    end

    // next values of the qualifiers for the rest of the device
    always_comb begin
        // idle: run low, ready high
        idle_next     = !run_sync && ready_eff;
        // presence bit is only meaningful under these conditions
        canvalid_next = run_sync &&
                        (can_transmit_enable || can_receive_enable);
    end

    // assemble the status byte; bit 1 stays zero
    always_comb begin
        status_next                 = OSS_STATUS_RESET;
        status_next[OSS_BIT_READY]  = ready_next;
        status_next[OSS_BIT_ACTIVE] = active_next;
        status_next[OSS_BIT_SAFE]   = safe_next;
        status_next[OSS_BIT_RAMCHK] = ramchk_next;
        status_next[OSS_BIT_EEPROG] = eeprog_next;
        status_next[OSS_BIT_BOOT]   = boot_next;
        status_next[OSS_BIT_UNUSED] = 1'b0;
        status_next[OSS_BIT_CANDET] = candet_next;
    end

    // a read of this byte is the only access that gets an answer
    always_comb begin
        read_hit = req.valid && !req.write &&
                   req.addr == OSS_STATUS_ADDR;
    end

    // register port: reads answer in any state, writes are dropped
    always_comb begin
        rsp_next      = '0;
        rsp_next.data = status_reg;
        if (read_hit) begin
            rsp_next.valid = 1'b1;
        end else begin
            // writes and other addresses change nothing, get no answer
            rsp_next.valid = 1'b0;
        end
    end

    // condition flops; everything clears on reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ready_reg  <= 1'b0;
            active_reg <= 1'b0;
            safe_reg   <= 1'b0;
            ramchk_reg <= 1'b0;
            eeprog_reg <= 1'b0;
            boot_reg   <= 1'b0;
            candet_reg <= 1'b0;
        end else begin
            ready_reg  <= ready_next;
            active_reg <= active_next;
            safe_reg   <= safe_next;
            ramchk_reg <= ramchk_next;
            eeprog_reg <= eeprog_next;
            boot_reg   <= boot_next;
            candet_reg <= candet_next;
        end
    end

    // qualifier flops for the rest of the device
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            idle_reg     <= 1'b0;
            canvalid_reg <= 1'b0;
        end else begin
            idle_reg     <= idle_next;
            canvalid_reg <= canvalid_next;
        end
    end

    // status byte image, the source of both the output and the answer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_reg <= OSS_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // answer flop; a pulse in flight when reset comes must not escape
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // pin and status bit share one next value, so they always agree
    assign ready_pin         = ready_reg;
    assign status_out        = status_reg;

    // qualifiers and the answer leave straight from their flops
    assign cfg_write_allowed = idle_reg;
    assign can_status_valid  = canvalid_reg;
    assign rsp               = rsp_reg;

endmodule // oss_status_reporter

//--- tb/oss_status_reporter_monitor.sv
/* checker on the status reporter ports.
   assumes one core clock and a synchronous low reset. */
module oss_status_reporter_monitor
    import oss_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // inputs
    input wire logic       run_pin,
    input wire oss_src_t   src,
    input wire logic       can_transmit_enable,
    input wire logic       can_receive_enable,
    input wire oss_req_t   req,
    // outputs
    input wire oss_rsp_t   rsp,
    input wire logic       ready_pin,
    input wire logic       cfg_write_allowed,
    input wire logic       can_status_valid,
    input wire logic [7:0] status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic rd;
    logic frz;
    // decoded read; modes 6 and 7 are the top two codes
    assign rd  = req.valid && !req.write && req.addr == OSS_STATUS_ADDR;
    assign frz = src.can_init_done && src.op_mode >= OSS_MODE_FREEZE_A;
    a_read_answer: assert property (
        rd |=> rsp.valid && rsp.data == $past(status_out))
        else $error("read not answered");
    a_no_answer: assert property (!rd |=> !rsp.valid)
        else $error("answer without read");
    a_ready_mirror: assert property (status_out[7] == ready_pin)
        else $error("ready bit differs from pin");
    a_ready_eeprom_write_in_progress: assert property (
        src.eeprom_write_in_progress |=> !ready_pin && status_out[3])
        else $error("ready high while programming");
    a_busy_bits: assert property (
        1 |=> status_out[4:2] == $past({src.ram_check_in_progress,
            src.eeprom_write_in_progress, src.boot_load_in_progress}))
        else $error("busy bits wrong");
    a_safe_set: assert property (
        src.selftest_fail || src.bootload_fail || status_out[5]
        |=> status_out[5])
        else $error("safe bit not set or lost");
    a_unused_zero: assert property (status_out[1] == 1'b0)
        else $error("unused bit set");
    a_can_detect: assert property (
        !frz |=> status_out[0] == $past(src.can_detect))
        else $error("presence bit wrong");
    a_can_freeze: assert property (frz |=> $stable(status_out[0]))
        else $error("presence bit moved while frozen");
    a_idle_ready: assert property (cfg_write_allowed |-> ready_pin)
        else $error("idle without ready");
endmodule // oss_status_reporter_monitor

bind oss_status_reporter oss_status_reporter_monitor
    oss_status_reporter_monitor_inst (
    .core_clk(core_clk), .rst_n(rst_n), .run_pin(run_pin), .src(src),
    .can_transmit_enable(can_transmit_enable),
    .can_receive_enable(can_receive_enable), .req(req), .rsp(rsp),
    .ready_pin(ready_pin), .cfg_write_allowed(cfg_write_allowed),
    .can_status_valid(can_status_valid), .status_out(status_out));

//--- tb/oss_host_model.sv
/* host model: launches register accesses asked for by the bench.
   assumes the answer is a one-cycle pulse, caught here into rdata. */
module oss_host_model
    import oss_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // bench side
    input wire logic        go,
    input wire logic        wr,
    input wire logic [15:0] addr,
    output logic            got,
    output logic [7:0]      rdata,
    // register port
    output oss_req_t        req,
    input wire oss_rsp_t    rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle fields toggle so a stale value never looks like a request
    always_ff @(posedge core_clk) begin
        if (!rst_n) req <= '0;
        else req <= go ? {1'b1, wr, addr, ~req.wdata}
                       : {1'b0, ~req.write, ~req.addr, ~req.wdata};
        got <= rsp.valid;
        if (rsp.valid) rdata <= rsp.data;
    end
endmodule // oss_host_model

//--- tb/oss_status_reporter_tb.sv
/* self-checking bench for the status reporter.
   assumes 1-cycle source latency and 5 cycles for the run pin. */
module oss_status_reporter_tb
    import oss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_n, run_pin, go, wr, got, safe;
    logic        can_transmit_enable, can_receive_enable, ready_pin;
    logic        cfg_write_allowed, can_status_valid;
    logic [7:0]  status_out, rdata, e;
    logic [15:0] addr, r;
    oss_src_t    src;
    oss_req_t    req;
    oss_rsp_t    rsp;
    int          fail_count, checks, p, i;

    oss_status_reporter oss_status_reporter_inst (.core_clk(core_clk),
        .rst_n(rst_n), .run_pin(run_pin), .src(src),
        .can_transmit_enable(can_transmit_enable),
        .can_receive_enable(can_receive_enable), .req(req), .rsp(rsp),
        .ready_pin(ready_pin), .cfg_write_allowed(cfg_write_allowed),
        .can_status_valid(can_status_valid), .status_out(status_out));
    oss_host_model oss_host_model_inst (.core_clk(core_clk), .rst_n(rst_n),
        .go(go), .wr(wr), .addr(addr), .got(got), .rdata(rdata),
        .req(req), .rsp(rsp));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected byte; presence bit keeps b0 while frozen
    function automatic logic [7:0] exp_st(input oss_src_t s,
        input logic run, input logic sf, input logic b0);
        exp_st = {s.core_ready & ~s.eeprom_write_in_progress,
            run & s.normal_mode, sf, s.ram_check_in_progress,
            s.eeprom_write_in_progress, s.boot_load_in_progress, 1'b0,
            (s.can_init_done && s.op_mode >= 3'h6) ? b0 : s.can_detect};
    endfunction
    task chk(input string n, input logic [7:0] x, input logic [7:0] y);
        checks++;
        if (x !== y) begin
            fail_count++;
            $display("wrong value %s exp %h seen %h", n, x, y);
        end
    endtask
    task print_verdict;
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one access; a missing answer to a read ends the run
    task access(input logic w, input logic [15:0] a, input logic ans,
        input logic [7:0] x);
        int k;
        go = 1;
        wr = w;
        addr = a;
        @(negedge core_clk);
        go = 0;
        for (k = 0; k < 4 && got !== 1'b1; k++) @(negedge core_clk);
        chk("answer", {7'h0, ans}, {7'h0, got});
        if (ans && got !== 1'b1) print_verdict();
        if (ans) chk("read data", x, rdata);
        repeat (4) @(negedge core_clk);
    endtask

    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        rst_n = 0;
        run_pin = 0;
        go = 0;
        wr = 0;
        addr = OSS_STATUS_ADDR;
        src = '0;
        can_transmit_enable = 0;
        can_receive_enable = 0;
        fail_count = 0;
        checks = 0;
        safe = 0;
        r = 16'h0038;
        e = '0;
        repeat (16) @(negedge core_clk);
        rst_n = 1;
        repeat (2) @(negedge core_clk);
        access(0, OSS_STATUS_ADDR, 1, OSS_STATUS_RESET);
        access(1, OSS_STATUS_ADDR, 0, 8'h00);
        access(0, 16'h800f, 0, 8'h00);
        access(0, OSS_STATUS_ADDR, 1, OSS_STATUS_RESET);
        // random sources, run low then high; reads at random, back to back
        for (p = 0; p < 2; p++) begin
            run_pin = p[0];
            repeat (8) @(negedge core_clk);
            for (i = 0; i < 150; i++) begin
                r = lfsr(r);
                src = r[11:0];
                src.selftest_fail = (p == 1 && i == 70);
                src.bootload_fail = 1'b0;
                can_transmit_enable = r[12];
                can_receive_enable = r[13];
                go = r[14];
                safe |= src.selftest_fail;
                e = exp_st(src, p[0], safe, e[0]);
                @(negedge core_clk);
                chk("status high", {4'h0, e[7:4]},
                    {4'h0, status_out[7:4]});
                chk("status low", {4'h0, e[3:0]},
                    {4'h0, status_out[3:0]});
                chk("ready", {7'h0, e[7]}, {7'h0, ready_pin});
                chk("idle", {7'h0, ~p[0] & e[7]},
                    {7'h0, cfg_write_allowed});
                chk("can ok", {7'h0, p[0] & (r[12] | r[13])},
                    {7'h0, can_status_valid});
            end
        end
        go = 0;
        // reset mid-run: the sticky safe bit and all others must clear
        src = '0;
        run_pin = 0;
        rst_n = 0;
        repeat (4) @(negedge core_clk);
        rst_n = 1;
        @(negedge core_clk);
        chk("status after reset", OSS_STATUS_RESET, status_out);
        access(0, OSS_STATUS_ADDR, 1, OSS_STATUS_RESET);
        // a boot-load failure pulse alone also enters safe mode
        src.bootload_fail = 1'b1;
        @(negedge core_clk);
        src.bootload_fail = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("safe bit", 8'h01 << OSS_BIT_SAFE, status_out);
        print_verdict();
    end
endmodule // oss_status_reporter_tb
